/* inc/uart_lms_pkg.sv */
// constants for the serial line, modem control and status register block
package uart_lms_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_IER = 3'h1;
   localparam logic [2:0] ADDR_FCR = 3'h2;
   localparam logic [2:0] ADDR_LCR = 3'h3;
   localparam logic [2:0] ADDR_MCR = 3'h4;
   localparam logic [2:0] ADDR_LSR = 3'h5;
   localparam logic [2:0] ADDR_MSR = 3'h6;
   localparam logic [2:0] ADDR_SPR = 3'h7;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int LCR_STOP = 2;
   localparam int LCR_PEN = 3;
   localparam int LCR_EVEN = 4;
   localparam int LCR_FORCE = 5;
   localparam int LCR_BRK = 6;
   localparam int LCR_DIV = 7;
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_OUT1 = 2;
   localparam int MCR_OUT2 = 3;
   localparam int MCR_LOOP = 4;
   localparam int IER_MODEM = 3;
   localparam int FCR_EN = 0;
   localparam int FCR_RXRST = 1;
   localparam int FCR_TXRST = 2;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] LCR_RST = 8'h00;
   localparam logic [7:0] MCR_RST = 8'h00;
   localparam logic [7:0] IER_RST = 8'h00;
   localparam logic [7:0] SPR_RST = 8'hFF;
   localparam logic [15:0] DIV_RST = 16'h0001;
   // ************************************************************
   // fifo and timing counts, multi-function pin selects
   // ************************************************************
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   localparam logic [4:0] HOLD_DEPTH = 5'h01;
   localparam logic [5:0] TICKS_BIT = 6'h10;
   localparam logic [5:0] TICKS_HALF = 6'h08;
   localparam logic [5:0] TICKS_STOP15 = 6'h18;
   localparam logic [5:0] TICKS_STOP2 = 6'h20;
   localparam logic [1:0] MF_OUT2 = 2'h0;
   localparam logic [1:0] MF_BAUD = 2'h1;
   localparam logic [1:0] MF_RXRDY = 2'h2;
endpackage

/* src/uart_line_modem_status_regs.sv */
// serial channel with line format, modem control and status registers
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - forced parity sends mark or space constant
// - break bit holds serial output at space
// - divisor-access bit maps divisor over data registers
// - terminal-ready bit drives its pin inverted
// - request-to-send bit drives its pin inverted
// - user output one feeds ring in loopback
// - user output two inverted on multi-function pin
// - loopback bit selects internal local loopback
// - data-ready reads one while receive data held
// - overrun flags, drops new character, keeps fifo
// - parity tag belongs to head character
// - framing tag belongs to head character
// - break loads one character, waits for mark
// - holding-empty follows transmit holding or fifo
// - transmitter-empty needs holding and shifter empty
// - error summary set while tagged entries remain
// - modem deltas set on change, raise interrupt
// - ring delta only on end of ringing
// - upper modem status shows inverted input pins
// - loopback returns modem control bits as status
// - scratch register, eight bits, resets to ones
// - bit rate is clock over sixteen over divisor
// - unforced parity odd or even by select
// - modem status read clears its interrupt
module uart_line_modem_status_regs
   import uart_lms_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic serial_in,
   output logic serial_out,
   input wire logic clear_to_send_in_n,
   input wire logic data_set_ready_in_n,
   input wire logic ring_in_n,
   input wire logic carrier_detect_in_n,
   input wire logic [1:0] mf_select,
   output logic terminal_ready_out_n,
   output logic request_to_send_out_n,
   output logic multi_function_out_n,
   output logic modem_irq
);
   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
      TX_PAR = 5'b01000, TX_STOP = 5'b10000
   } tx_state_t;
   typedef enum logic [5:0] {
      RX_IDLE = 6'b000001, RX_START = 6'b000010, RX_DATA = 6'b000100,
      RX_PAR = 6'b001000, RX_STOP = 6'b010000, RX_BRK = 6'b100000
   } rx_state_t;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [7:0] word_mask(input logic [1:0] wl);
      word_mask = 8'(8'hFF >> (2'h3 - wl));
   endfunction

   function automatic logic [2:0] last_bit(input logic [1:0] wl);
      last_bit = 3'(wl) + 3'h4;
   endfunction

   function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line_format_control);
      logic x;
      x = ^(d & word_mask(line_format_control[1:0]));
      if (line_format_control[LCR_FORCE]) begin
         par_bit = ~line_format_control[LCR_EVEN];
      end else begin
         par_bit = line_format_control[LCR_EVEN] ? x : ~x;
      end
   endfunction

   // ************************************************************
   // registers and state
   // ************************************************************
   logic [7:0] lcr_ff, mcr_ff, ier_ff, spr_ff, rdata_ff;
   logic [15:0] div_ff, baud_cnt_ff;
   logic baud_tick_ff, fifo_en_ff, overrun_ff, modem_irq_ff;
   logic [7:0] tx_mem [16];
   logic [10:0] rx_mem [16];
   logic [3:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
   logic [4:0] tx_cnt_ff, rx_cnt_ff, err_cnt_ff;
   tx_state_t tx_state_ff;
   rx_state_t rx_state_ff;
   logic [5:0] tx_tick_ff, rx_tick_ff;
   logic [2:0] tx_idx_ff, rx_idx_ff;
   logic [7:0] tx_shift_ff, rx_shift_ff;
   logic tx_par_ff, tx_line_ff, rx_zero_ff, rx_perr_ff;
   logic [3:0] delta_ff, modem_prev_ff;
   logic serial_out_ff, dtr_n_ff, rts_n_ff, mf_n_ff;

   logic loop_en, div_sel, wr_data, rd_data, rd_lsr, rd_msr, wr_fcr;
   logic [4:0] limit;
   logic tx_push, tx_pop, rx_done, rx_push, rx_pop, rx_head_err;
   logic [10:0] rx_entry, rx_head;
   logic rx_src, rx_ferr, rx_brk;
   logic [3:0] modem_now;
   logic [5:0] stop_len;

   assign loop_en = mcr_ff[MCR_LOOP];
   assign div_sel = lcr_ff[LCR_DIV];
   assign wr_data = reg_wr && reg_addr == ADDR_DATA && !div_sel;
   assign rd_data = reg_rd && reg_addr == ADDR_DATA && !div_sel;
   assign rd_lsr = reg_rd && reg_addr == ADDR_LSR;
   assign rd_msr = reg_rd && reg_addr == ADDR_MSR;
   assign wr_fcr = reg_wr && reg_addr == ADDR_FCR;
   // non-fifo mode behaves as a one-deep holding register
   assign limit = fifo_en_ff ? FIFO_DEPTH : HOLD_DEPTH;
   assign tx_push = wr_data && tx_cnt_ff != limit;
   assign tx_pop = tx_state_ff == TX_IDLE && tx_cnt_ff != 5'h00;
   assign rx_pop = rd_data && rx_cnt_ff != 5'h00;
   assign rx_head = rx_mem[rx_rp_ff];
   assign rx_head_err = |rx_head[10:8];
   // loopback feeds the receiver from the transmit line, break included
   assign rx_src = loop_en ? (tx_line_ff & ~lcr_ff[LCR_BRK]) : serial_in;
   assign rx_done = rx_state_ff == RX_STOP && baud_tick_ff && rx_tick_ff == 6'h0F;
   assign rx_ferr = ~rx_src;
   assign rx_brk = rx_zero_ff & ~rx_src;
   assign rx_entry = {rx_brk, rx_ferr, rx_perr_ff, rx_shift_ff};
   assign rx_push = rx_done && rx_cnt_ff != limit;
   assign stop_len = !lcr_ff[LCR_STOP] ? TICKS_BIT :
                     (lcr_ff[1:0] == 2'h0 ? TICKS_STOP15 : TICKS_STOP2);
   // status order is cd, ri, dsr, cts
   assign modem_now = loop_en ?
      {mcr_ff[MCR_OUT2], mcr_ff[MCR_OUT1], mcr_ff[MCR_DTR], mcr_ff[MCR_RTS]} :
      ~{carrier_detect_in_n, ring_in_n, data_set_ready_in_n, clear_to_send_in_n};

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         lcr_ff <= LCR_RST;
         mcr_ff <= MCR_RST;
         ier_ff <= IER_RST;
         spr_ff <= SPR_RST;
         div_ff <= DIV_RST;
         fifo_en_ff <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_DATA: if (div_sel) div_ff[7:0] <= reg_wdata;
            ADDR_IER: begin
               if (div_sel) div_ff[15:8] <= reg_wdata;
               else ier_ff <= {4'h0, reg_wdata[3:0]};
            end
            ADDR_FCR: fifo_en_ff <= reg_wdata[FCR_EN];
            ADDR_LCR: lcr_ff <= reg_wdata;
            ADDR_MCR: mcr_ff <= {3'h0, reg_wdata[4:0]};
            ADDR_SPR: spr_ff <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ************************************************************
   // baud generator: one 16x tick every divisor clocks
   // ************************************************************
   always_ff @(posedge core_clk) begin
      // a divisor write restarts the count so a shorter divisor never overshoots
      if (srst || div_ff == 16'h0000 || (reg_wr && div_sel &&
          (reg_addr == ADDR_DATA || reg_addr == ADDR_IER))) begin
         baud_cnt_ff <= 16'h0000;
         baud_tick_ff <= 1'b0;
      end else if (baud_cnt_ff >= div_ff - 16'h0001) begin
         baud_cnt_ff <= 16'h0000;
         baud_tick_ff <= 1'b1;
      end else begin
         baud_cnt_ff <= baud_cnt_ff + 16'h0001;
         baud_tick_ff <= 1'b0;
      end
   end

   // ************************************************************
   // transmit fifo and shifter
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (tx_push) tx_mem[tx_wp_ff] <= reg_wdata;
   end

   always_ff @(posedge core_clk) begin
      if (srst || (wr_fcr && reg_wdata[FCR_TXRST])) begin
         tx_wp_ff <= 4'h0;
         tx_rp_ff <= 4'h0;
         tx_cnt_ff <= 5'h00;
      end else begin
         if (tx_push) tx_wp_ff <= tx_wp_ff + 4'h1;
         if (tx_pop) tx_rp_ff <= tx_rp_ff + 4'h1;
         tx_cnt_ff <= tx_cnt_ff + 5'(tx_push) - 5'(tx_pop);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_state_ff <= TX_IDLE;
         tx_tick_ff <= 6'h00;
         tx_idx_ff <= 3'h0;
         tx_shift_ff <= 8'h00;
         tx_par_ff <= 1'b0;
         tx_line_ff <= 1'b1;
      end else begin
         case (tx_state_ff)
            TX_IDLE: begin
               tx_line_ff <= 1'b1;
               if (tx_pop) begin
                  tx_shift_ff <= tx_mem[tx_rp_ff];
                  tx_par_ff <= par_bit(tx_mem[tx_rp_ff], lcr_ff);
                  tx_line_ff <= 1'b0;
                  tx_tick_ff <= 6'h00;
                  tx_state_ff <= TX_START;
               end
            end
            TX_START, TX_DATA, TX_PAR: if (baud_tick_ff) begin
               tx_tick_ff <= tx_tick_ff + 6'h01;
               if (tx_tick_ff == TICKS_BIT - 6'h01) begin
                  tx_tick_ff <= 6'h00;
                  if (tx_state_ff == TX_START) begin
                     tx_line_ff <= tx_shift_ff[0];
                     tx_idx_ff <= 3'h0;
                     tx_state_ff <= TX_DATA;
                  end else if (tx_state_ff == TX_DATA && tx_idx_ff != last_bit(lcr_ff[1:0])) begin
                     tx_shift_ff <= tx_shift_ff >> 1;
                     tx_line_ff <= tx_shift_ff[1];
                     tx_idx_ff <= tx_idx_ff + 3'h1;
                  end else if (tx_state_ff == TX_DATA && lcr_ff[LCR_PEN]) begin
                     tx_line_ff <= tx_par_ff;
                     tx_state_ff <= TX_PAR;
                  end else begin
                     tx_line_ff <= 1'b1;
                     tx_state_ff <= TX_STOP;
                  end
               end
            end
            TX_STOP: if (baud_tick_ff) begin
               tx_tick_ff <= tx_tick_ff + 6'h01;
               if (tx_tick_ff == stop_len - 6'h01) begin
                  tx_tick_ff <= 6'h00;
                  tx_state_ff <= TX_IDLE;
               end
            end
            default: tx_state_ff <= TX_IDLE;
         endcase
      end
   end

   // ************************************************************
   // receiver
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rx_state_ff <= RX_IDLE;
         rx_tick_ff <= 6'h00;
         rx_idx_ff <= 3'h0;
         rx_shift_ff <= 8'h00;
         rx_zero_ff <= 1'b0;
         rx_perr_ff <= 1'b0;
      end else begin
         case (rx_state_ff)
            RX_IDLE: if (!rx_src) begin
               rx_tick_ff <= 6'h00;
               rx_shift_ff <= 8'h00;
               rx_perr_ff <= 1'b0;
               rx_state_ff <= RX_START;
            end
            RX_START: if (baud_tick_ff) begin
               rx_tick_ff <= rx_tick_ff + 6'h01;
               if (rx_tick_ff == TICKS_HALF - 6'h01) begin
                  // a glitch shorter than half a bit is not a start bit
                  rx_tick_ff <= 6'h00;
                  rx_idx_ff <= 3'h0;
                  rx_zero_ff <= 1'b1;
                  rx_state_ff <= rx_src ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA, RX_PAR, RX_STOP: if (baud_tick_ff) begin
               rx_tick_ff <= rx_tick_ff + 6'h01;
               if (rx_tick_ff == TICKS_BIT - 6'h01) begin
                  rx_tick_ff <= 6'h00;
                  rx_zero_ff <= rx_zero_ff & ~rx_src;
                  if (rx_state_ff == RX_DATA) begin
                     rx_shift_ff[rx_idx_ff] <= rx_src;
                     rx_idx_ff <= rx_idx_ff + 3'h1;
                     if (rx_idx_ff == last_bit(lcr_ff[1:0]))
                        rx_state_ff <= lcr_ff[LCR_PEN] ? RX_PAR : RX_STOP;
                  end else if (rx_state_ff == RX_PAR) begin
                     rx_perr_ff <= rx_src != par_bit(rx_shift_ff, lcr_ff);
                     rx_state_ff <= RX_STOP;
                  end else begin
                     rx_state_ff <= rx_brk ? RX_BRK : RX_IDLE;
                  end
               end
            end
            RX_BRK: if (rx_src) rx_state_ff <= RX_IDLE;
            default: rx_state_ff <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rx_push) rx_mem[rx_wp_ff] <= rx_entry;
   end

   always_ff @(posedge core_clk) begin
      if (srst || (wr_fcr && reg_wdata[FCR_RXRST])) begin
         rx_wp_ff <= 4'h0;
         rx_rp_ff <= 4'h0;
         rx_cnt_ff <= 5'h00;
         err_cnt_ff <= 5'h00;
      end else begin
         if (rx_push) rx_wp_ff <= rx_wp_ff + 4'h1;
         if (rx_pop) rx_rp_ff <= rx_rp_ff + 4'h1;
         rx_cnt_ff <= rx_cnt_ff + 5'(rx_push) - 5'(rx_pop);
         err_cnt_ff <= err_cnt_ff + 5'(rx_push && |rx_entry[10:8])
                       - 5'(rx_pop && rx_head_err);
      end
   end

   // overrun is cleared by a status read; a new overrun in that cycle wins
   always_ff @(posedge core_clk) begin
      if (srst) overrun_ff <= 1'b0;
      else overrun_ff <= (rx_done && !rx_push) || (overrun_ff && !rd_lsr);
   end

   // ************************************************************
   // modem status change detection
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         modem_prev_ff <= modem_now;
         delta_ff <= 4'h0;
         modem_irq_ff <= 1'b0;
      end else begin
         modem_prev_ff <= modem_now;
         delta_ff[0] <= (modem_now[0] ^ modem_prev_ff[0]) || (delta_ff[0] && !rd_msr);
         delta_ff[1] <= (modem_now[1] ^ modem_prev_ff[1]) || (delta_ff[1] && !rd_msr);
         delta_ff[2] <= (modem_prev_ff[2] && !modem_now[2]) || (delta_ff[2] && !rd_msr);
         delta_ff[3] <= (modem_now[3] ^ modem_prev_ff[3]) || (delta_ff[3] && !rd_msr);
         modem_irq_ff <= ier_ff[IER_MODEM] && |delta_ff && !rd_msr;
      end
   end

   // ************************************************************
   // pins and read data
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         serial_out_ff <= 1'b1;
         dtr_n_ff <= 1'b1;
         rts_n_ff <= 1'b1;
         mf_n_ff <= 1'b1;
      end else begin
         // in loopback the line sits at mark, unless a break is asked for
         serial_out_ff <= lcr_ff[LCR_BRK] ? 1'b0 : (loop_en | tx_line_ff);
         dtr_n_ff <= loop_en | ~mcr_ff[MCR_DTR];
         rts_n_ff <= loop_en | ~mcr_ff[MCR_RTS];
         case (mf_select)
            MF_OUT2: mf_n_ff <= loop_en | ~mcr_ff[MCR_OUT2];
            MF_BAUD: mf_n_ff <= ~baud_tick_ff;
            MF_RXRDY: mf_n_ff <= rx_cnt_ff == 5'h00;
            default: mf_n_ff <= 1'b1;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || !reg_rd) begin
         rdata_ff <= 8'h00;
      end else begin
         case (reg_addr)
            ADDR_DATA: rdata_ff <= div_sel ? div_ff[7:0] : rx_head[7:0];
            ADDR_IER: rdata_ff <= div_sel ? div_ff[15:8] : ier_ff;
            ADDR_FCR: rdata_ff <= {fifo_en_ff, fifo_en_ff, 6'h00};
            ADDR_LCR: rdata_ff <= lcr_ff;
            ADDR_MCR: rdata_ff <= mcr_ff;
            ADDR_LSR: rdata_ff <= {err_cnt_ff != 5'h00,
               tx_cnt_ff == 5'h00 && tx_state_ff == TX_IDLE,
               tx_cnt_ff == 5'h00,
               rx_cnt_ff != 5'h00 && rx_head[10],
               rx_cnt_ff != 5'h00 && rx_head[9],
               rx_cnt_ff != 5'h00 && rx_head[8],
               overrun_ff, rx_cnt_ff != 5'h00};
            ADDR_MSR: rdata_ff <= {modem_now, delta_ff};
            ADDR_SPR: rdata_ff <= spr_ff;
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   assign reg_rdata = rdata_ff;
   assign serial_out = serial_out_ff;
   assign terminal_ready_out_n = dtr_n_ff;
   assign request_to_send_out_n = rts_n_ff;
   assign multi_function_out_n = mf_n_ff;
   assign modem_irq = modem_irq_ff;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_tx_load_forced;
      tx_pop && lcr_ff[LCR_PEN] && lcr_ff[LCR_FORCE];
   endsequence
   sequence s_msr_read_loop;
      rd_msr && loop_en;
   endsequence

   a_forced_parity: assert property (s_tx_load_forced |=> tx_par_ff == ~$past(lcr_ff[LCR_EVEN]))
      else $error("forced parity bit wrong");
   a_break_low: assert property (lcr_ff[LCR_BRK] ##1 lcr_ff[LCR_BRK] |=> !serial_out)
      else $error("break does not hold line low");
   a_divisor_read: assert property (reg_rd && reg_addr == ADDR_DATA && div_sel |=> reg_rdata == $past(div_ff[7:0]))
      else $error("divisor low not returned");
   a_dtr_pin: assert property (!loop_en |=> terminal_ready_out_n == !$past(mcr_ff[MCR_DTR]))
      else $error("terminal ready pin not inverted");
   a_rts_pin: assert property (!loop_en |=> request_to_send_out_n == !$past(mcr_ff[MCR_RTS]))
      else $error("request to send pin not inverted");
   a_loop_status: assert property (s_msr_read_loop |=> reg_rdata[7:4] == $past({mcr_ff[MCR_OUT2],
      mcr_ff[MCR_OUT1], mcr_ff[MCR_DTR], mcr_ff[MCR_RTS]}))
      else $error("loopback modem status wrong");
   a_pin_status: assert property (rd_msr && !loop_en |=> reg_rdata[7:4] == ~$past({carrier_detect_in_n, ring_in_n, data_set_ready_in_n, clear_to_send_in_n}))
      else $error("modem status not inverted pins");
   a_data_ready: assert property (rd_lsr |=> reg_rdata[0] == ($past(rx_cnt_ff) != 5'h00))
      else $error("data ready flag wrong");
   a_overrun_keep: assert property (rx_done && rx_cnt_ff == limit && !rx_pop |=> overrun_ff && $stable(rx_cnt_ff))
      else $error("overrun did not protect fifo");
   a_thr_empty: assert property (tx_push |=> ((tx_cnt_ff != 5'h00) and (rd_lsr |=> !reg_rdata[5])))
      else $error("holding empty after load");
   a_temt_thre: assert property (rd_lsr |=> !reg_rdata[6] || reg_rdata[5])
      else $error("transmitter empty with holding full");
   a_err_summary: assert property (rd_lsr && err_cnt_ff == 5'h00 |=> !reg_rdata[7])
      else $error("error summary set without tags");
   a_delta_irq: assert property (ier_ff[IER_MODEM] && |delta_ff && !rd_msr |=> modem_irq)
      else $error("modem interrupt missing");
   a_ring_edge: assert property ($rose(delta_ff[2]) |-> $past(modem_prev_ff[2]) && !$past(modem_now[2]))
      else $error("ring delta on wrong edge");
   a_msr_clear: assert property (rd_msr && modem_now == modem_prev_ff |=> delta_ff == 4'h0 && !modem_irq)
      else $error("status read did not clear deltas");
   a_baud_period: assert property (baud_tick_ff |-> $past(baud_cnt_ff) == $past(div_ff) - 16'h0001)
      else $error("baud tick period wrong");
endmodule

/* tb/uart_remote_model.sv */
// remote serial device that sends frames on the receive line
`timescale 1ns/10ps
module uart_remote_model (
   input wire logic core_clk,
   output logic line
);
   // ****
   // frame sender
   // ****
   initial line = 1'b1;
   // 16 clocks a bit: divisor 1 at clock over sixteen
   task automatic send(input logic [7:0] d, input logic par, input logic stp);
      logic [10:0] f;
      f = {stp, par, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line <= f[i];
         repeat (16) @(posedge core_clk);
      end
      // idle at mark so the next start edge is clean
      line <= 1'b1;
      repeat (32) @(posedge core_clk);
   endtask
endmodule

/* tb/uart_line_modem_status_regs_tb_top.sv */
// self-checking bench for the line and modem status register block
`timescale 1ns/10ps
module uart_line_modem_status_regs_tb_top;
   import uart_lms_pkg::*;
   logic core_clk, srst, reg_wr, reg_rd, serial_out, line, cts_n, dsr_n, ri_n, cd_n;
   logic dtr_n, rts_n, mf_n, modem_irq;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, v;
   logic [1:0] mf_select;
   int n_errors = 0, total_checks = 0, cyc = 0;
   uart_line_modem_status_regs dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .serial_in(line), .serial_out(serial_out), .clear_to_send_in_n(cts_n),
      .data_set_ready_in_n(dsr_n), .ring_in_n(ri_n), .carrier_detect_in_n(cd_n),
      .mf_select(mf_select), .terminal_ready_out_n(dtr_n), .request_to_send_out_n(rts_n),
      .multi_function_out_n(mf_n), .modem_irq(modem_irq));
   uart_remote_model far (.core_clk(core_clk), .line(line));
   // ****
   // bus and compare tasks
   // ****
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   // data stand one cycle only, so take them at the edge that ends that cycle
   task automatic rd(input logic [2:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      v = reg_rdata;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset();
      rd(ADDR_SPR); chk("scratch", v, 8'hFF);
      rd(ADDR_LSR); chk("line_status", v, 8'h60);
      chk("pins", {5'h0, dtr_n, rts_n, mf_n}, 8'h07);
      wr(ADDR_SPR, 8'h5A); rd(ADDR_SPR); chk("scratch", v, 8'h5A);
   endtask
   task automatic t_modem();
      wr(ADDR_IER, 8'h08); wr(ADDR_MCR, 8'h0B); wt(3);
      chk("pins", {5'h0, dtr_n, rts_n, mf_n}, 8'h00);
      mf_select <= 2'h3; wt(3); chk("mf", {7'h0, mf_n}, 8'h01);
      wr(ADDR_MCR, 8'h00); cts_n <= 1'b0; wt(5);
      chk("irq", {7'h0, modem_irq}, 8'h01);
      rd(ADDR_MSR); chk("modem_status", v, 8'h11);
      wt(2); chk("irq", {7'h0, modem_irq}, 8'h00);
      rd(ADDR_MSR); chk("modem_status", v, 8'h10);
      cts_n <= 1'b1; wt(5); rd(ADDR_MSR); chk("modem_status", v, 8'h01);
   endtask
   // ring status rising means ringing started: no ring delta until it falls
   task automatic t_loop();
      mf_select <= 2'h0; wr(ADDR_MCR, 8'h1F); wt(3);
      chk("pins", {5'h0, dtr_n, rts_n, mf_n}, 8'h07);
      rd(ADDR_MSR); chk("modem_status", v, 8'hFB);
      wr(ADDR_MCR, 8'h10); wt(3); rd(ADDR_MSR); chk("modem_status", v, 8'h0F);
      wr(ADDR_LCR, 8'h03); wr(ADDR_DATA, 8'hC3); wt(220);
      rd(ADDR_LSR); chk("line_status", v & 8'h7F, 8'h61);
      rd(ADDR_DATA); chk("loop_data", v, 8'hC3);
      wr(ADDR_MCR, 8'h00);
   endtask
   task automatic t_break_div();
      wr(ADDR_LCR, 8'h43); wt(40); chk("tx", {7'h0, serial_out}, 8'h00);
      wr(ADDR_LCR, 8'h83); wt(3); chk("tx", {7'h0, serial_out}, 8'h01);
      wr(ADDR_DATA, 8'h02); rd(ADDR_DATA); chk("divisor_low", v, 8'h02);
      wr(ADDR_DATA, 8'h01); wr(ADDR_LCR, 8'h03);
      rd(ADDR_IER); chk("int_enable", v, 8'h08);
   endtask
   task automatic t_rx(input logic [7:0] line_format_control, d, input logic p, s, input logic [7:0] line_status);
      wr(ADDR_LCR, line_format_control); far.send(d, p, s);
      rd(ADDR_LSR); chk("line_status", v & 8'h7F, line_status);
      mf_select <= 2'h2; wt(2); chk("mf", {7'h0, mf_n}, 8'h00);
      rd(ADDR_DATA); chk("rx_data", v, d);
   endtask
   // ****
   // main sequence and hang guard
   // ****
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         close_out();
      end
   end
   initial begin
      {srst, cts_n, dsr_n, ri_n, cd_n} = 5'h1F;
      {reg_wr, reg_rd, reg_addr, reg_wdata, mf_select} = 15'h0;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      t_reset(); t_modem(); t_loop(); t_break_div();
      t_rx(8'h2B, 8'hA5, 1'b1, 1'b1, 8'h61); t_rx(8'h2B, 8'h5A, 1'b0, 1'b1, 8'h65);
      t_rx(8'h3B, 8'h3C, 1'b0, 1'b1, 8'h61); t_rx(8'h1B, 8'hA5, 1'b0, 1'b1, 8'h61);
      t_rx(8'h0B, 8'h81, 1'b1, 1'b1, 8'h61); t_rx(8'h2B, 8'h3C, 1'b1, 1'b0, 8'h69);
      close_out();
   end
endmodule
